// ### design/lcdh_defines.svh
// Constants of the LCD column driver host port: instruction codes,
// status bit positions, reset values and timing counts.
// Assumes a 125 MHz system clock.
`ifndef LCDH_DEFINES_SVH
`define LCDH_DEFINES_SVH

// Clock period in picoseconds
`define LCDH_CLK_PS 8000
// Time the reset status stays up after the reset pin releases
`define LCDH_INIT_NS 1000
`define LCDH_INIT_CYC ((`LCDH_INIT_NS * 1000 + `LCDH_CLK_PS - 1) / `LCDH_CLK_PS)
// Length of one internal operation in cycles
`define LCDH_BUSY_CYC 4'h4
// Line scan divider terminal count
`define LCDH_LINE_DIV 8'h3F

// Instruction opcodes, matched against the top bits of the byte
`define LCDH_OP_DISP 7'h1F
`define LCDH_OP_COL 2'h1
`define LCDH_OP_PAGE 5'h17
`define LCDH_OP_START 2'h3

// Status byte bit positions
`define LCDH_ST_BUSY 7
`define LCDH_ST_ONOFF 5
`define LCDH_ST_RESET 4

// Reset values
`define LCDH_RST_START 6'h00
`define LCDH_RST_COL 6'h00
`define LCDH_RST_PAGE 3'h0

`endif

// ### design/lcdh_host_port.sv
// Host parallel port and display memory control of a two-half LCD
// column driver, with per-half page, column, start line and display state.
// Assumes host pins are synchronous to clk_i and the strobe is slow.
`timescale 1ns/1ps
`include "lcdh_defines.svh"

// Behaviour
// - No select: no access, no drive, state kept
// - Reset pin acts regardless of selects
// - Writes staged on strobe, then moved internally
// - Select and direction decode four access kinds
// - Memory read returns previously latched byte
// - Status read needs no dummy access
// - Reset pin: display off, start line zero
// - Reset pin low: only status reads accepted
// - Busy refuses accesses; shown in bit seven
// - Display off drives non-selected segment level
// - Display flip-flop set by instruction, bit five
// - Reset pin low blanks all segments
// - Page loaded only by instruction
// - Column loaded, increments per data access
// - Memory one lights dot, zero leaves off
// - Start line instruction latches six bits
// - Frame sync presets line counter from start
// - Each select enables one controller half
// - Column instruction loads six-bit field
module lcdh_host_port
  import lcdh_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire lcdh_bus_t bus_i,
  input wire logic reset_in_n_i,
  input wire logic frame_sync_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic busy_o,
  output logic [1:0][63:0] seg_o,
  output logic [1:0][5:0] scan_line_o
);

  function automatic lcdh_kind_t decode_kind(input logic rs, input logic rw);
    decode_kind = lcdh_kind_t'({rs, rw});
  endfunction

  function automatic lcdh_instr_t decode_instr(input logic [7:0] d);
    if (d[7:1] == `LCDH_OP_DISP) begin
      decode_instr = I_DISP;
    end else if (d[7:6] == `LCDH_OP_COL) begin
      decode_instr = I_COL;
    end else if (d[7:3] == `LCDH_OP_PAGE) begin
      decode_instr = I_PAGE;
    end else if (d[7:6] == `LCDH_OP_START) begin
      decode_instr = I_START;
    end else begin
      decode_instr = I_NONE;
    end
  endfunction

  logic strobe_q;
  logic rise;
  logic fall;
  logic [1:0] sel;
  logic any_sel;
  logic hsel;
  lcdh_kind_t kind;
  logic busy;
  logic reset_stat;
  logic ready;
  logic [7:0] status_byte;
  logic [7:0] in_stage_q;
  lcdh_kind_t op_kind_q;
  logic [1:0] op_sel_q;
  logic op_pend_q;
  logic [1:0] apply;
  logic [3:0] busy_cnt_q;
  logic [7:0] init_cnt_q;
  logic rd_pend_q;
  logic [1:0] rd_sel_q;
  logic [1:0][2:0] page_q;
  logic [1:0][5:0] col_q;
  logic [1:0][5:0] start_q;
  logic [1:0] disp_on_q;
  logic [1:0][7:0] out_stage_q;
  logic [7:0] mem_q [0:1][0:511];
  logic [7:0] line_div_q;
  logic line_tick;
  logic [1:0][5:0] line;
  logic [1:0][63:0] seg_q;
  logic [7:0] data_q;
  logic data_oe_q;

  // Strobe edge detection and access decode
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= bus_i.strobe;
    end
  end

  assign rise = bus_i.strobe && !strobe_q;
  assign fall = !bus_i.strobe && strobe_q;
  assign sel = {bus_i.half_select_b, bus_i.half_select_a};
  assign any_sel = |sel;
  assign hsel = !sel[0];
  assign kind = decode_kind(bus_i.reg_select, bus_i.read_write);
  assign busy = (busy_cnt_q != 4'h0) || op_pend_q;
  assign reset_stat = !reset_in_n_i || (init_cnt_q != 8'h00);
  assign ready = !busy && !reset_stat;
  assign apply = op_pend_q ? (op_sel_q & {2{reset_in_n_i}}) : 2'b00;
  assign busy_o = busy;

  always_comb begin
    status_byte = 8'h00;
    status_byte[`LCDH_ST_BUSY] = busy;
    status_byte[`LCDH_ST_ONOFF] = !disp_on_q[hsel];
    status_byte[`LCDH_ST_RESET] = reset_stat;
  end

  // Reset status hold after the reset pin releases
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      init_cnt_q <= 8'(`LCDH_INIT_CYC);
    end else if (!reset_in_n_i) begin
      init_cnt_q <= 8'(`LCDH_INIT_CYC);
    end else if (init_cnt_q != 8'h00) begin
      init_cnt_q <= init_cnt_q - 8'h01;
    end
  end

  // Input staging: capture on strobe fall, apply one cycle later
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_stage_q <= 8'h00;
      op_kind_q <= K_INSTR;
      op_sel_q <= 2'b00;
      op_pend_q <= 1'b0;
    end else if (fall && any_sel && !bus_i.read_write && ready) begin
      in_stage_q <= bus_i.data;
      op_kind_q <= kind;
      op_sel_q <= sel;
      op_pend_q <= 1'b1;
    end else begin
      op_pend_q <= 1'b0;
    end
  end

  // Internal operation time
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_cnt_q <= 4'h0;
    end else if (fall && any_sel && !bus_i.read_write && ready) begin
      busy_cnt_q <= `LCDH_BUSY_CYC;
    end else if (busy_cnt_q != 4'h0) begin
      busy_cnt_q <= busy_cnt_q - 4'h1;
    end
  end

  // Display memory write from the input stage
  always_ff @(posedge clk_i) begin
    for (int h = 0; h < 2; h++) begin
      if (apply[h] && op_kind_q == K_WRITE) begin
        mem_q[h][{page_q[h], col_q[h]}] <= in_stage_q;
      end
    end
  end

  // Page, start line and display flip-flop
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      page_q <= {2{`LCDH_RST_PAGE}};
      start_q <= {2{`LCDH_RST_START}};
      disp_on_q <= 2'b00;
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (!reset_in_n_i) begin
          disp_on_q[h] <= 1'b0;
          start_q[h] <= `LCDH_RST_START;
        end else if (apply[h] && op_kind_q == K_INSTR) begin
          unique case (decode_instr(in_stage_q))
            I_DISP: begin
              disp_on_q[h] <= in_stage_q[0];
            end
            I_PAGE: begin
              page_q[h] <= in_stage_q[2:0];
            end
            I_START: begin
              start_q[h] <= in_stage_q[5:0];
            end
            I_COL, I_NONE: begin
            end
          endcase
        end
      end
    end
  end

  // Column counter
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      col_q <= {2{`LCDH_RST_COL}};
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (apply[h] && op_kind_q == K_INSTR && decode_instr(in_stage_q) == I_COL) begin
          col_q[h] <= in_stage_q[5:0];
        end else if (apply[h] && op_kind_q == K_WRITE) begin
          col_q[h] <= col_q[h] + 6'h01;
        end else if (fall && rd_pend_q && rd_sel_q[h]) begin
          col_q[h] <= col_q[h] + 6'h01;
        end
      end
    end
  end

  // Output stage: latched at the end of a data read
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_stage_q <= '0;
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (fall && rd_pend_q && rd_sel_q[h]) begin
          out_stage_q[h] <= mem_q[h][{page_q[h], col_q[h]}];
        end
      end
    end
  end

  // Data read bookkeeping
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_pend_q <= 1'b0;
      rd_sel_q <= 2'b00;
    end else if (rise && any_sel && kind == K_READ && ready) begin
      rd_pend_q <= 1'b1;
      rd_sel_q <= sel;
    end else if (fall) begin
      rd_pend_q <= 1'b0;
    end
  end

  // Bus drive during the strobe high phase
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_q <= 8'h00;
      data_oe_q <= 1'b0;
    end else if (rise && any_sel && kind == K_STATUS) begin
      data_q <= status_byte;
      data_oe_q <= 1'b1;
    end else if (rise && any_sel && kind == K_READ && ready) begin
      data_q <= out_stage_q[hsel];
      data_oe_q <= 1'b1;
    end else if (fall) begin
      data_oe_q <= 1'b0;
    end
  end

  assign data_o = data_q;
  assign data_oe_o = data_oe_q;

  // Line tick divider
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_div_q <= 8'h00;
    end else if (line_div_q == `LCDH_LINE_DIV) begin
      line_div_q <= 8'h00;
    end else begin
      line_div_q <= line_div_q + 8'h01;
    end
  end

  assign line_tick = (line_div_q == `LCDH_LINE_DIV);

  // Per-half scan and segment outputs
  for (genvar h = 0; h < 2; h++) begin : g_half
    lcdh_scan u_scan (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .line_tick_i(line_tick),
      .frame_sync_i(frame_sync_i),
      .start_line_i(start_q[h]),
      .line_o(line[h])
    );
    for (genvar c = 0; c < 64; c++) begin : g_col
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          seg_q[h][c] <= 1'b0;
        end else if (disp_on_q[h] && reset_in_n_i) begin
          seg_q[h][c] <= mem_q[h][{line[h][5:3], 6'(c)}][line[h][2:0]];
        end else begin
          seg_q[h][c] <= 1'b0;
        end
      end
    end
  end

  assign seg_o = seg_q;
  assign scan_line_o = line;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_write_taken;
    fall && any_sel && kind == K_WRITE && ready;
  endsequence

  sequence s_read_taken;
    rise && sel == 2'b01 && kind == K_READ && ready;
  endsequence

  a_noselect_quiet: assert property (
    (rise && !any_sel && !data_oe_o) |=> !data_oe_o)
    else $error("bus driven without a select");

  a_noselect_state: assert property (
    (fall && !any_sel) |=> !op_pend_q)
    else $error("access taken without a select");

  a_write_staged: assert property (
    s_write_taken |=> op_pend_q && in_stage_q == $past(bus_i.data))
    else $error("write byte not staged");

  a_write_memory: assert property (
    (s_write_taken and (sel == 2'b01))
      |=> ##1 mem_q[0][{page_q[0], col_q[0] - 6'h01}] == $past(bus_i.data, 2))
    else $error("staged byte not moved into memory");

  a_dummy_read: assert property (
    s_read_taken |=> data_oe_o && data_o == $past(out_stage_q[0]))
    else $error("data read did not return latched byte");

  a_status_read: assert property (
    (rise && sel == 2'b01 && kind == K_STATUS)
      |=> data_oe_o && data_o[`LCDH_ST_ONOFF] == !$past(disp_on_q[0])
        && data_o[`LCDH_ST_BUSY] == $past(busy))
    else $error("status read wrong");

  a_reset_off: assert property (
    !reset_in_n_i |=> disp_on_q == 2'b00 && start_q == '0)
    else $error("reset pin did not clear display and start line");

  a_reset_refuse: assert property (
    (fall && !reset_in_n_i) |=> !op_pend_q)
    else $error("access taken during reset");

  a_busy_refuse: assert property (
    (fall && busy) |=> $stable(in_stage_q) && !op_pend_q)
    else $error("access taken while busy");

  a_busy_length: assert property (
    s_write_taken |=> busy [*4] ##1 !busy)
    else $error("busy length wrong");

  a_reset_blank: assert property (
    !reset_in_n_i |=> seg_o == '0)
    else $error("segments not blanked under reset");

  a_page_hold: assert property (
    !(apply[0] && op_kind_q == K_INSTR) |=> $stable(page_q[0]))
    else $error("page changed without instruction");

  a_col_step: assert property (
    (apply[0] && op_kind_q == K_WRITE) |=> col_q[0] == $past(col_q[0]) + 6'h01)
    else $error("column not advanced after write");

  a_start_load: assert property (
    (apply[0] && op_kind_q == K_INSTR && in_stage_q[7:6] == `LCDH_OP_START)
      |=> start_q[0] == $past(in_stage_q[5:0]))
    else $error("start line not loaded");

endmodule

// ### design/lcdh_pkg.sv
// Types of the LCD column driver host port.
// Assumes lcdh_defines.svh holds the numeric constants.
package lcdh_pkg;

  // Host bus pins as sampled by the port
  typedef struct packed {
    logic half_select_a;
    logic half_select_b;
    logic reg_select;
    logic read_write;
    logic strobe;
    logic [7:0] data;
  } lcdh_bus_t;

  // Access kind, coded as {reg_select, read_write}
  typedef enum logic [1:0] {
    K_INSTR = 2'b00,
    K_STATUS = 2'b01,
    K_WRITE = 2'b10,
    K_READ = 2'b11
  } lcdh_kind_t;

  // Decoded instruction
  typedef enum logic [2:0] {
    I_NONE = 3'b000,
    I_DISP = 3'b001,
    I_COL = 3'b010,
    I_PAGE = 3'b011,
    I_START = 3'b100
  } lcdh_instr_t;

endpackage

// ### design/lcdh_scan.sv
// Line scan counter of one controller half.
// Assumes a one-cycle line tick from a divider and a frame sync level.
`timescale 1ns/1ps
`include "lcdh_defines.svh"

module lcdh_scan (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic line_tick_i,
  input wire logic frame_sync_i,
  input wire logic [5:0] start_line_i,
  output logic [5:0] line_o
);

  logic [5:0] line_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_q <= `LCDH_RST_START;
    end else if (frame_sync_i) begin
      line_q <= start_line_i;
    end else if (line_tick_i) begin
      line_q <= line_q + 6'h01;
    end
  end

  assign line_o = line_q;

  a_frame_preset: assert property (@(posedge clk_i) disable iff (!nrst_i)
    frame_sync_i |=> line_o == $past(start_line_i))
    else $error("line counter not preset from start line");

  a_line_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!frame_sync_i && !line_tick_i) |=> $stable(line_o))
    else $error("line counter moved without tick");

endmodule

// ### tb/lcdh_host_model.sv
// Host processor model for the parallel port of the LCD column driver.
// Assumes bus pins may change at the falling clock edge.
`timescale 1ns/1ps

module lcdh_host_model
  import lcdh_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] data_i,
  input wire logic data_oe_i,
  output lcdh_bus_t bus_o
);
  initial begin
    bus_o = '0;
  end

  // One strobe cycle: setup, high width and low gap in clock cycles
  task automatic access(input logic [1:0] sel, input lcdh_kind_t kind,
                        input logic [7:0] d, input int su, input int hi, input int lo,
                        output logic [7:0] q, output logic oe);
    @(negedge clk_i);
    bus_o.half_select_a = sel[0];
    bus_o.half_select_b = sel[1];
    {bus_o.reg_select, bus_o.read_write} = kind;
    if (!kind[0]) begin
      bus_o.data = d;
    end
    repeat (su) @(negedge clk_i);
    bus_o.strobe = 1'b1;
    repeat (hi) @(negedge clk_i);
    q = data_i;
    oe = data_oe_i;
    bus_o.strobe = 1'b0;
    @(negedge clk_i);
    bus_o.half_select_a = 1'b0;
    bus_o.half_select_b = 1'b0;
    // Released data lines do not keep the last value
    bus_o.data = ~bus_o.data;
    repeat (lo) @(negedge clk_i);
  endtask
endmodule

// ### tb/test_lcdh_host_port.sv
// Self-checking testbench of the LCD column driver host port.
// Assumes the host model drives the bus; the bench drives the other pins.
`timescale 1ns/1ps

module test_lcdh_host_port;
  import lcdh_pkg::*;

  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reset_in_n_i = 1'b1;
  logic frame_sync_i = 1'b0;
  lcdh_bus_t bus;
  logic [7:0] data_o;
  logic data_oe_o;
  logic busy_o;
  logic [1:0][63:0] seg_o;
  logic [1:0][5:0] scan_line_o;
  logic [7:0] q;
  logic oe;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;

  always #4 clk_i = ~clk_i;

  lcdh_host_port uut (
    .clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus), .reset_in_n_i(reset_in_n_i),
    .frame_sync_i(frame_sync_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .busy_o(busy_o), .seg_o(seg_o), .scan_line_o(scan_line_o)
  );

  lcdh_host_model host (
    .clk_i(clk_i), .data_i(data_o), .data_oe_i(data_oe_o), .bus_o(bus)
  );

  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      results();
    end
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask

  task automatic wr(input logic [1:0] sel, input lcdh_kind_t k, input logic [7:0] d);
    host.access(sel, k, d, 18, 57, 57, q, oe);
  endtask

  task automatic rd(input logic [1:0] sel, input lcdh_kind_t k);
    host.access(sel, k, 8'h00, 18, 57, 57, q, oe);
  endtask

  // Poll status until reset and busy are both clear
  task automatic wait_ready;
    for (int i = 0; i < 20; i++) begin
      rd(2'b01, K_STATUS);
      if (q[7] === 1'b0 && q[4] === 1'b0) begin
        break;
      end
    end
    check("ready status", q & 8'h90, 8'h00);
  endtask

  task automatic t_status;
    rd(2'b01, K_STATUS);
    check("status drive", oe, 1'b1);
    check("status at init", q, 8'h30);
    rd(2'b00, K_STATUS);
    check("unselected drive", oe, 1'b0);
    wait_ready();
  endtask

  task automatic t_display;
    wr(2'b01, K_INSTR, 8'h3F);
    rd(2'b01, K_STATUS);
    check("display on", q, 8'h00);
    rd(2'b10, K_STATUS);
    check("half b status", q, 8'h20);
    wr(2'b01, K_INSTR, 8'h00);
    rd(2'b01, K_STATUS);
    check("no-op instruction", q, 8'h00);
    wr(2'b01, K_INSTR, 8'h3E);
    rd(2'b01, K_STATUS);
    check("display off", q, 8'h20);
  endtask

  // Dummy read first, then the byte at the column set
  task automatic read_at(input logic [1:0] sel, input logic [7:0] col_op);
    wr(sel, K_INSTR, col_op);
    rd(sel, K_READ);
    rd(sel, K_READ);
  endtask

  task automatic t_data;
    wr(2'b01, K_INSTR, 8'hBA);
    wr(2'b01, K_INSTR, 8'h45);
    wr(2'b01, K_WRITE, 8'hA5);
    wr(2'b01, K_WRITE, 8'h5A);
    read_at(2'b01, 8'h45);
    check("read first", q, 8'hA5);
    rd(2'b01, K_READ);
    check("read next", q, 8'h5A);
    wr(2'b01, K_INSTR, 8'h45);
    wr(2'b00, K_WRITE, 8'hFF);
    rd(2'b01, K_READ);
    rd(2'b01, K_READ);
    check("unselected write", q, 8'hA5);
    wr(2'b01, K_INSTR, 8'h7F);
    wr(2'b01, K_WRITE, 8'h11);
    wr(2'b01, K_WRITE, 8'h22);
    read_at(2'b01, 8'h40);
    check("column wrap", q, 8'h22);
    read_at(2'b01, 8'h7F);
    check("last column", q, 8'h11);
    wr(2'b10, K_INSTR, 8'hBA);
    wr(2'b10, K_INSTR, 8'h45);
    wr(2'b10, K_WRITE, 8'hC3);
    read_at(2'b01, 8'h45);
    check("half a kept", q, 8'hA5);
    read_at(2'b10, 8'h45);
    check("half b", q, 8'hC3);
    wr(2'b01, K_INSTR, 8'hBB);
    wr(2'b01, K_WRITE, 8'h3C);
    wr(2'b01, K_INSTR, 8'hBA);
    read_at(2'b01, 8'h45);
    check("page kept", q, 8'hA5);
    wr(2'b11, K_INSTR, 8'hBC);
    wr(2'b11, K_INSTR, 8'h40);
    wr(2'b11, K_WRITE, 8'h96);
    read_at(2'b10, 8'h40);
    check("both halves b", q, 8'h96);
    read_at(2'b01, 8'h40);
    check("both halves a", q, 8'h96);
  endtask

  task automatic t_busy;
    host.access(2'b01, K_INSTR, 8'h3F, 1, 2, 0, q, oe);
    check("busy pin", busy_o, 1'b1);
    host.access(2'b01, K_STATUS, 8'h00, 0, 2, 0, q, oe);
    check("busy bit", q[7], 1'b1);
    wait_ready();
    check("busy pin clear", busy_o, 1'b0);
  endtask

  task automatic t_scan;
    wr(2'b01, K_INSTR, 8'hBA);
    wr(2'b01, K_INSTR, 8'h47);
    wr(2'b01, K_WRITE, 8'h08);
    wr(2'b01, K_WRITE, 8'h00);
    wr(2'b01, K_INSTR, 8'hD3);
    wr(2'b01, K_INSTR, 8'h3F);
    @(negedge clk_i);
    frame_sync_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("scan line", scan_line_o[0], 6'h13);
    check("dot on", seg_o[0][7], 1'b1);
    check("dot off", seg_o[0][8], 1'b0);
    wr(2'b01, K_INSTR, 8'h3E);
    check("dot blank off", seg_o[0][7], 1'b0);
    wr(2'b01, K_INSTR, 8'h3F);
    check("dot kept", seg_o[0][7], 1'b1);
    reset_in_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check("reset blank", seg_o[0][7], 1'b0);
    check("start cleared", scan_line_o[0], 6'h00);
    wr(2'b01, K_INSTR, 8'h3F);
    rd(2'b01, K_STATUS);
    check("reset status", q & 8'h30, 8'h30);
    reset_in_n_i = 1'b1;
    frame_sync_i = 1'b0;
    wait_ready();
    check("still off", q, 8'h20);
  endtask

  initial begin
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    t_status();
    t_display();
    t_data();
    t_busy();
    t_scan();
    results();
  end
endmodule
